// ### verilog/iwd_pkg.sv
package iwd_pkg;

    // word layout
    localparam int OPC_LSB   = 0;
    localparam int OPC_W     = 6;
    localparam int RA_LSB    = 27;
    localparam int RB_LSB    = 22;
    localparam int RC_LSB    = 17;
    localparam int REG_W     = 5;
    localparam int SIMM_LSB  = 6;
    localparam int SIMM_W    = 16;
    localparam int EXT_LSB   = 6;
    localparam int EXT_W     = 11;
    localparam int EXT_CODE_LSB = 5;   // upper six extension bits
    localparam int EXT_CODE_W   = 6;
    localparam int EXT_IMM_W    = 5;
    localparam int JIMM_LSB  = 6;
    localparam int JIMM_W    = 26;
    localparam int PC_KEEP_W = 4;
    localparam int JSHIFT    = 2;

    // reset value of decoded outputs
    localparam logic [31:0] OUT_RST = 32'h0000_0000;

    // operation classes
    typedef enum logic [6:0] {
        IWD_RESERVED,
        IWD_CALL, IWD_JMPI,
        IWD_LDBU, IWD_LDB, IWD_LDHU, IWD_LDH, IWD_LDW,
        IWD_LDBU_IO, IWD_LDB_IO, IWD_LDHU_IO, IWD_LDH_IO, IWD_LDW_IO,
        IWD_STB, IWD_STH, IWD_STW, IWD_STB_IO, IWD_STH_IO, IWD_STW_IO,
        IWD_BRANCH_ALWAYS, IWD_BGE, IWD_BLT, IWD_BNE, IWD_BEQ,
        IWD_BGEU, IWD_BLTU,
        IWD_ADDI, IWD_ANDI, IWD_ORI, IWD_XORI, IWD_MULI,
        IWD_ANDHI, IWD_ORHI, IWD_XORHI,
        IWD_CMPGEI, IWD_CMPLTI, IWD_CMPNEI, IWD_CMPEQI,
        IWD_CMPGEUI, IWD_CMPLTUI,
        IWD_INITDA, IWD_INITD, IWD_FLUSHDA, IWD_FLUSHD,
        IWD_CUSTOM, IWD_RDPRS,
        IWD_ADD, IWD_SUB, IWD_MUL, IWD_DIV, IWD_DIVU,
        IWD_MULXUU, IWD_MULXSU, IWD_MULXSS,
        IWD_AND, IWD_OR, IWD_XOR, IWD_NOR,
        IWD_ROL, IWD_ROLI, IWD_ROR, IWD_SLL, IWD_SLLI,
        IWD_SRL, IWD_SRLI, IWD_SRA, IWD_SRAI,
        IWD_CMPGE, IWD_CMPLT, IWD_CMPNE, IWD_CMPEQ,
        IWD_CMPGEU, IWD_CMPLTU,
        IWD_ERET, IWD_RET, IWD_BRET, IWD_JMP, IWD_CALLR,
        IWD_NEXTPC, IWD_TRAP, IWD_BREAK,
        IWD_RDCTL, IWD_WRCTL, IWD_WRPRS, IWD_SYNC,
        IWD_FLUSHP, IWD_FLUSHI, IWD_INITI
    } iwd_op_e;

    typedef enum logic [1:0] {
        IWD_FMT_I, IWD_FMT_R, IWD_FMT_J
    } iwd_fmt_e;

    localparam logic [5:0] OPC_RTYPE = 6'h3a;

endpackage

// ### verilog/iwd_ext_classify.sv
`timescale 1ns/1ps

// maps a register-format extension code to its operation class
module iwd_ext_classify
    import iwd_pkg::*;
(
    input  wire logic [EXT_W-1:0] ext,
    output iwd_op_e               op,
    output logic                  uses_imm
);

    logic [EXT_CODE_W-1:0] code;

    assign code = ext[EXT_CODE_LSB +: EXT_CODE_W];

    // class lookup; the immediate forms carry a shift count, or a trap or break number, low
    always_comb
    begin
        uses_imm = 1'b0;
        case (code)
            6'h31: op = IWD_ADD;
            6'h39: op = IWD_SUB;
            6'h27: op = IWD_MUL;
            6'h25: op = IWD_DIV;
            6'h24: op = IWD_DIVU;
            6'h07: op = IWD_MULXUU;
            6'h17: op = IWD_MULXSU;
            6'h1f: op = IWD_MULXSS;
            6'h0e: op = IWD_AND;
            6'h16: op = IWD_OR;
            6'h1e: op = IWD_XOR;
            6'h06: op = IWD_NOR;
            6'h03: op = IWD_ROL;
            6'h02:
            begin
                op       = IWD_ROLI;
                uses_imm = 1'b1;
            end
            6'h0b: op = IWD_ROR;
            6'h13: op = IWD_SLL;
            6'h12:
            begin
                op       = IWD_SLLI;
                uses_imm = 1'b1;
            end
            6'h1b: op = IWD_SRL;
            6'h1a:
            begin
                op       = IWD_SRLI;
                uses_imm = 1'b1;
            end
            6'h3b: op = IWD_SRA;
            6'h3a:
            begin
                op       = IWD_SRAI;
                uses_imm = 1'b1;
            end
            6'h08: op = IWD_CMPGE;
            6'h10: op = IWD_CMPLT;
            6'h18: op = IWD_CMPNE;
            6'h20: op = IWD_CMPEQ;
            6'h28: op = IWD_CMPGEU;
            6'h30: op = IWD_CMPLTU;
            6'h01: op = IWD_ERET;
            6'h05: op = IWD_RET;
            6'h09: op = IWD_BRET;
            6'h0d: op = IWD_JMP;
            6'h1d: op = IWD_CALLR;
            6'h1c: op = IWD_NEXTPC;
            6'h2d:
            begin
                op       = IWD_TRAP;    // trap number in the low bits
                uses_imm = 1'b1;
            end
            6'h34:
            begin
                op       = IWD_BREAK;
                uses_imm = 1'b1;
            end
            6'h26: op = IWD_RDCTL;
            6'h2e: op = IWD_WRCTL;
            6'h14: op = IWD_WRPRS;
            6'h36: op = IWD_SYNC;
            6'h04: op = IWD_FLUSHP;
            6'h0c: op = IWD_FLUSHI;
            6'h29: op = IWD_INITI;
            default: op = IWD_RESERVED;
        endcase
    end

endmodule

// ### verilog/iwd_decoder.sv
// Contract
// - immediate format: opcode, two registers, immediate
// - immediate format: A and immediate source, B destination
// - sign-extend immediate except logical, unsigned compares
// - register format: opcode, three registers, extension
// - register format: A, B sources, C destination
// - small immediate in extension low bits; unused zero
// - jump format: opcode plus 26-bit immediate
// - opcode 0x00 call, 0x01 direct jump
// - opcode 0x3a register format, 0x00 and 0x01 jump format, others immediate
// - unassigned opcodes and extensions flagged reserved
// - load opcodes and their bypass variants
// - store opcodes and their bypass variants
// - branch opcodes
// - immediate arithmetic and logic opcodes
// - immediate compare opcodes
// - cache, custom and previous-set read opcodes
// - register arithmetic extension codes
// - register logic extension codes
// - shift and rotate extension codes
// - register compare extension codes
// - control-flow extension codes
// - system extension codes
`timescale 1ns/1ps

module iwd_decoder
    import iwd_pkg::*;
#(
    parameter int PC_W = 32
)
(
    input  wire logic              CLOCK,
    input  wire logic              SRST,
    input  wire logic              IN_VALID,
    input  wire logic [31:0]       IN_WORD,
    input  wire logic [PC_W-1:0]   IN_PC,
    output logic                   OUT_VALID,
    output iwd_fmt_e               OUT_FORMAT,
    output iwd_op_e                OUT_OP,
    output logic                   OUT_RESERVED,
    output logic [OPC_W-1:0]       OUT_MAJOR_OPCODE,
    output logic [EXT_W-1:0]       OUT_OPCODE_EXTENSION,
    output logic [REG_W-1:0]       OUT_SRC_A,
    output logic [REG_W-1:0]       OUT_SRC_B,
    output logic                   OUT_SRC_B_USED,
    output logic [REG_W-1:0]       OUT_DEST,
    output logic [SIMM_W-1:0]      OUT_SHORT_IMMEDIATE,
    output logic [31:0]            OUT_IMM_EXT,
    output logic [JIMM_W-1:0]      OUT_JUMP_IMMEDIATE,
    output logic [PC_W-1:0]        OUT_JUMP_TARGET
);

    ////////////////////////////////////////////////////////////////////
    // field extraction

    logic [OPC_W-1:0]  major_opcode;
    logic [EXT_W-1:0]  opcode_extension;
    logic [REG_W-1:0]  fld_a;
    logic [REG_W-1:0]  fld_b;
    logic [REG_W-1:0]  fld_c;
    logic [SIMM_W-1:0] short_immediate;
    logic [JIMM_W-1:0] jump_immediate;

    // fixed positions, independent of format
    assign major_opcode     = IN_WORD[OPC_LSB +: OPC_W];
    assign fld_a            = IN_WORD[RA_LSB +: REG_W];
    assign fld_b            = IN_WORD[RB_LSB +: REG_W];
    assign fld_c            = IN_WORD[RC_LSB +: REG_W];
    assign short_immediate  = IN_WORD[SIMM_LSB +: SIMM_W];
    assign opcode_extension = IN_WORD[EXT_LSB +: EXT_W];
    assign jump_immediate   = IN_WORD[JIMM_LSB +: JIMM_W];

    ////////////////////////////////////////////////////////////////////
    // major opcode classification

    iwd_op_e  maj_op;
    iwd_op_e  ext_op;
    logic     ext_uses_imm;
    logic     zero_ext;

    iwd_ext_classify u_ext
    (
        .ext      (opcode_extension),
        .op       (ext_op),
        .uses_imm (ext_uses_imm)
    );

    // every assigned opcode; gaps fall to reserved
    always_comb
    begin
        zero_ext = 1'b0;
        case (major_opcode)
            6'h00: maj_op = IWD_CALL;
            6'h01: maj_op = IWD_JMPI;
            6'h03: maj_op = IWD_LDBU;
            6'h07: maj_op = IWD_LDB;
            6'h0b: maj_op = IWD_LDHU;
            6'h0f: maj_op = IWD_LDH;
            6'h17: maj_op = IWD_LDW;
            6'h23: maj_op = IWD_LDBU_IO;
            6'h27: maj_op = IWD_LDB_IO;
            6'h2b: maj_op = IWD_LDHU_IO;
            6'h2f: maj_op = IWD_LDH_IO;
            6'h37: maj_op = IWD_LDW_IO;
            6'h05: maj_op = IWD_STB;
            6'h0d: maj_op = IWD_STH;
            6'h15: maj_op = IWD_STW;
            6'h25: maj_op = IWD_STB_IO;
            6'h2d: maj_op = IWD_STH_IO;
            6'h35: maj_op = IWD_STW_IO;
            6'h06: maj_op = IWD_BRANCH_ALWAYS;
            6'h0e: maj_op = IWD_BGE;
            6'h16: maj_op = IWD_BLT;
            6'h1e: maj_op = IWD_BNE;
            6'h26: maj_op = IWD_BEQ;
            6'h2e: maj_op = IWD_BGEU;
            6'h36: maj_op = IWD_BLTU;
            6'h04: maj_op = IWD_ADDI;
            6'h24: maj_op = IWD_MULI;
            6'h0c:
            begin
                maj_op   = IWD_ANDI;
                zero_ext = 1'b1;
            end
            6'h14:
            begin
                maj_op   = IWD_ORI;
                zero_ext = 1'b1;
            end
            6'h1c:
            begin
                maj_op   = IWD_XORI;
                zero_ext = 1'b1;
            end
            6'h2c:
            begin
                maj_op   = IWD_ANDHI;
                zero_ext = 1'b1;
            end
            6'h34:
            begin
                maj_op   = IWD_ORHI;
                zero_ext = 1'b1;
            end
            6'h3c:
            begin
                maj_op   = IWD_XORHI;
                zero_ext = 1'b1;
            end
            6'h08: maj_op = IWD_CMPGEI;
            6'h10: maj_op = IWD_CMPLTI;
            6'h18: maj_op = IWD_CMPNEI;
            6'h20: maj_op = IWD_CMPEQI;
            6'h28:
            begin
                maj_op   = IWD_CMPGEUI;
                zero_ext = 1'b1;
            end
            6'h30:
            begin
                maj_op   = IWD_CMPLTUI;
                zero_ext = 1'b1;
            end
            6'h13: maj_op = IWD_INITDA;
            6'h33: maj_op = IWD_INITD;
            6'h1b: maj_op = IWD_FLUSHDA;
            6'h3b: maj_op = IWD_FLUSHD;
            6'h32: maj_op = IWD_CUSTOM;
            6'h38: maj_op = IWD_RDPRS;
            default: maj_op = IWD_RESERVED;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // format selection and operand roles

    iwd_fmt_e fmt;
    iwd_op_e  op;
    logic     ext_bad;
    logic     reserved;
    logic [REG_W-1:0] dest;
    logic [31:0]      imm_ext;

    // a nonzero unused extension field marks the word reserved, so a
    // malformed word is never executed as its look-alike
    assign ext_bad = !ext_uses_imm &&
                     (opcode_extension[EXT_IMM_W-1:0] != '0);

    always_comb
    begin
        if (major_opcode == OPC_RTYPE)
        begin
            fmt = IWD_FMT_R;
            op  = ext_bad ? IWD_RESERVED : ext_op;
        end
        else if (maj_op == IWD_CALL || maj_op == IWD_JMPI)
        begin
            fmt = IWD_FMT_J;
            op  = maj_op;
        end
        else
        begin
            fmt = IWD_FMT_I;
            op  = maj_op;
        end
    end

    assign reserved = (op == IWD_RESERVED);

    // destination: B in immediate format, C in register format
    assign dest = (fmt == IWD_FMT_R) ? fld_c : fld_b;

    // register format exposes the five-bit field, unsigned
    always_comb
    begin
        if (fmt == IWD_FMT_R)
            imm_ext = {27'h0000000, opcode_extension[EXT_IMM_W-1:0]};
        else if (zero_ext)
            imm_ext = {16'h0000, short_immediate};
        else
            imm_ext = {{16{short_immediate[SIMM_W-1]}},
                       short_immediate};
    end

    ////////////////////////////////////////////////////////////////////
    // output registers; one decode per accepted word, one cycle later

    always_ff @(posedge CLOCK)
    begin
        if (SRST)
            OUT_VALID <= 1'b0;
        else
            OUT_VALID <= IN_VALID;
    end

    // decode class; fields update only for valid words so idle cycles
    // keep the last decode for a consumer that is not yet ready
    always_ff @(posedge CLOCK)
    begin
        if (SRST)
        begin
            OUT_FORMAT   <= IWD_FMT_I;
            OUT_OP       <= IWD_RESERVED;
            OUT_RESERVED <= 1'b0;
        end
        else if (IN_VALID)
        begin
            OUT_FORMAT   <= fmt;
            OUT_OP       <= op;
            OUT_RESERVED <= reserved;
        end
    end

    // raw fields at fixed positions, exposed for every format
    always_ff @(posedge CLOCK)
    begin
        if (SRST)
        begin
            OUT_MAJOR_OPCODE     <= OUT_RST[OPC_W-1:0];
            OUT_OPCODE_EXTENSION <= OUT_RST[EXT_W-1:0];
            OUT_SRC_A            <= OUT_RST[REG_W-1:0];
            OUT_SRC_B            <= OUT_RST[REG_W-1:0];
            OUT_SHORT_IMMEDIATE  <= OUT_RST[SIMM_W-1:0];
            OUT_JUMP_IMMEDIATE   <= OUT_RST[JIMM_W-1:0];
        end
        else if (IN_VALID)
        begin
            OUT_MAJOR_OPCODE     <= major_opcode;
            OUT_OPCODE_EXTENSION <= opcode_extension;
            OUT_SRC_A            <= fld_a;
            OUT_SRC_B            <= fld_b;
            OUT_SHORT_IMMEDIATE  <= short_immediate;
            OUT_JUMP_IMMEDIATE   <= jump_immediate;
        end
    end

    // operand roles: which field is written, and the widened immediate
    always_ff @(posedge CLOCK)
    begin
        if (SRST)
        begin
            OUT_SRC_B_USED <= 1'b0;
            OUT_DEST       <= OUT_RST[REG_W-1:0];
            OUT_IMM_EXT    <= OUT_RST;
        end
        else if (IN_VALID)
        begin
            OUT_SRC_B_USED <= (fmt == IWD_FMT_R);
            OUT_DEST       <= dest;
            OUT_IMM_EXT    <= imm_ext;
        end
    end

    // jump target; keeps top bits, so reach is one 256-MB region
    always_ff @(posedge CLOCK)
    begin
        if (SRST)
        begin
            OUT_JUMP_TARGET <= OUT_RST[PC_W-1:0];
        end
        else if (IN_VALID)
        begin
            OUT_JUMP_TARGET <= {IN_PC[PC_W-1 -: PC_KEEP_W],
                                jump_immediate,
                                {JSHIFT{1'b0}}};
        end
    end

endmodule

// ### tb/iwd_decoder_assertions.sv
`timescale 1ns/1ps

// watches the decoder ports; every decode lands one edge after its word
module iwd_decoder_assertions
    import iwd_pkg::*;
#(
    parameter int PC_W = 32
)
(
    input wire logic              CLOCK,
    input wire logic              SRST,
    input wire logic              IN_VALID,
    input wire logic [31:0]       IN_WORD,
    input wire logic [PC_W-1:0]   IN_PC,
    input wire logic              OUT_VALID,
    input wire iwd_fmt_e          OUT_FORMAT,
    input wire iwd_op_e           OUT_OP,
    input wire logic              OUT_RESERVED,
    input wire logic [OPC_W-1:0]  OUT_MAJOR_OPCODE,
    input wire logic [EXT_W-1:0]  OUT_OPCODE_EXTENSION,
    input wire logic [REG_W-1:0]  OUT_SRC_A,
    input wire logic [REG_W-1:0]  OUT_SRC_B,
    input wire logic              OUT_SRC_B_USED,
    input wire logic [REG_W-1:0]  OUT_DEST,
    input wire logic [SIMM_W-1:0] OUT_SHORT_IMMEDIATE,
    input wire logic [31:0]       OUT_IMM_EXT,
    input wire logic [JIMM_W-1:0] OUT_JUMP_IMMEDIATE,
    input wire logic [PC_W-1:0]   OUT_JUMP_TARGET
);
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (SRST);

    ////////////////////////////////////////////////////////////////////////
    // a taken word, and a taken word of one major opcode
    sequence taken_s;
        IN_VALID;
    endsequence

    sequence taken_op_s(logic [5:0] opc);
        IN_VALID && IN_WORD[5:0] == opc;
    endsequence

    ////////////////////////////////////////////////////////////////////////
    valid_latency_a: assert property (taken_s |=> OUT_VALID)
        else $error("no decode one cycle after a taken word");
    idle_hold_a: assert property (!IN_VALID |=> !OUT_VALID
        && $stable(OUT_OP) && $stable(OUT_DEST))
        else $error("outputs moved without a taken word");
    opcode_fields_a: assert property (taken_s |=>
        OUT_MAJOR_OPCODE == $past(IN_WORD[5:0])
        && OUT_OPCODE_EXTENSION == $past(IN_WORD[16:6]))
        else $error("opcode fields wrong");
    reg_fields_a: assert property (taken_s |=>
        OUT_SRC_A == $past(IN_WORD[31:27])
        && OUT_SRC_B == $past(IN_WORD[26:22]))
        else $error("register fields wrong");
    imm_fields_a: assert property (taken_s |=>
        OUT_SHORT_IMMEDIATE == $past(IN_WORD[21:6])
        && OUT_JUMP_IMMEDIATE == $past(IN_WORD[31:6]))
        else $error("immediate fields wrong");
    jump_target_a: assert property (taken_s |=>
        OUT_JUMP_TARGET == {$past(IN_PC[PC_W-1-:4]),
        $past(IN_WORD[31:6]), 2'b00})
        else $error("jump target wrong");
    rtype_dest_a: assert property (taken_op_s(OPC_RTYPE) |=>
        OUT_FORMAT == IWD_FMT_R && OUT_SRC_B_USED
        && OUT_DEST == $past(IN_WORD[21:17]))
        else $error("register format destination wrong");
    itype_dest_a: assert property (taken_op_s(6'h04) |=>
        OUT_FORMAT == IWD_FMT_I && !OUT_SRC_B_USED
        && OUT_DEST == $past(IN_WORD[26:22]))
        else $error("immediate format destination wrong");
    sign_ext_a: assert property (taken_op_s(6'h04) |=>
        OUT_IMM_EXT == {{16{$past(IN_WORD[21])}}, $past(IN_WORD[21:6])})
        else $error("add immediate not sign extended");
    call_format_a: assert property (taken_op_s(6'h00) |=>
        OUT_FORMAT == IWD_FMT_J && OUT_OP == IWD_CALL)
        else $error("call not decoded as jump format");
    reserved_op_a: assert property (taken_op_s(6'h02) |=>
        OUT_RESERVED && OUT_OP == IWD_RESERVED)
        else $error("unassigned opcode not flagged");
endmodule

bind iwd_decoder iwd_decoder_assertions #(.PC_W(PC_W)) u_chk (
    .CLOCK(CLOCK), .SRST(SRST), .IN_VALID(IN_VALID), .IN_WORD(IN_WORD),
    .IN_PC(IN_PC), .OUT_VALID(OUT_VALID), .OUT_FORMAT(OUT_FORMAT),
    .OUT_OP(OUT_OP), .OUT_RESERVED(OUT_RESERVED),
    .OUT_MAJOR_OPCODE(OUT_MAJOR_OPCODE),
    .OUT_OPCODE_EXTENSION(OUT_OPCODE_EXTENSION),
    .OUT_SRC_A(OUT_SRC_A), .OUT_SRC_B(OUT_SRC_B),
    .OUT_SRC_B_USED(OUT_SRC_B_USED), .OUT_DEST(OUT_DEST),
    .OUT_SHORT_IMMEDIATE(OUT_SHORT_IMMEDIATE), .OUT_IMM_EXT(OUT_IMM_EXT),
    .OUT_JUMP_IMMEDIATE(OUT_JUMP_IMMEDIATE),
    .OUT_JUMP_TARGET(OUT_JUMP_TARGET)
);

// ### tb/iwd_fetch_model.sv
`timescale 1ns/1ps

// fetch stage: one word per call, changed only just after a rising edge
module iwd_fetch_model
(
    input  wire logic   clock,
    output logic        in_valid,
    output logic [31:0] in_word,
    output logic [31:0] in_pc
);
    // quiet at time zero so the decoder never sees an unknown strobe
    initial
    begin
        in_valid = 1'b0;
        in_word  = 32'h0000_0000;
        in_pc    = 32'h0000_0000;
    end

    // present a word from the next edge on
    task automatic send(input logic [31:0] w, input logic [31:0] pc);
        @(posedge clock);
        in_valid <= 1'b1;
        in_word  <= w;
        in_pc    <= pc;
    endtask

    // idle lines scramble, so a stale word cannot pass for a fresh one
    task automatic idle();
        @(posedge clock);
        in_valid <= 1'b0;
        in_word  <= ~in_word;
        in_pc    <= ~in_pc;
    endtask
endmodule

// ### tb/risc_instruction_word_decoder_tb_top.sv
`timescale 1ns/1ps

module risc_instruction_word_decoder_tb_top
    import iwd_pkg::*;
;
    localparam logic [63:0] OP_DEFINED  = 64'h1dfd_f9f9_59f9_f9fb;
    localparam logic [63:0] EXT_DEFINED = 64'h0e53_63f1_fddd_7bfe;

    logic CLOCK, SRST;
    wire logic IN_VALID;
    wire logic [31:0] IN_WORD, IN_PC;
    logic OUT_VALID, OUT_RESERVED, OUT_SRC_B_USED;
    iwd_fmt_e OUT_FORMAT;
    iwd_op_e OUT_OP;
    logic [5:0] OUT_MAJOR_OPCODE;
    logic [10:0] OUT_OPCODE_EXTENSION;
    logic [4:0] OUT_SRC_A, OUT_SRC_B, OUT_DEST;
    logic [15:0] OUT_SHORT_IMMEDIATE;
    logic [31:0] OUT_IMM_EXT, OUT_JUMP_TARGET;
    logic [25:0] OUT_JUMP_IMMEDIATE;
    int failures = 0;
    int samples_checked = 0;
    // bit 6 marks an extension code under the register-format opcode
    logic [6:0] op_codes [40] = '{7'h00, 7'h01, 7'h03, 7'h0f, 7'h37,
        7'h23, 7'h0d, 7'h35, 7'h06, 7'h36, 7'h1e, 7'h24, 7'h3c, 7'h0c,
        7'h08, 7'h30, 7'h13, 7'h3b, 7'h32, 7'h38, 7'h71, 7'h79, 7'h5f,
        7'h64, 7'h46, 7'h5e, 7'h7a, 7'h43, 7'h4b, 7'h53, 7'h68, 7'h50,
        7'h41, 7'h74, 7'h5c, 7'h5d, 7'h66, 7'h69, 7'h44, 7'h76};
    iwd_op_e op_exp [40] = '{IWD_CALL, IWD_JMPI, IWD_LDBU, IWD_LDH,
        IWD_LDW_IO, IWD_LDBU_IO, IWD_STH, IWD_STW_IO, IWD_BRANCH_ALWAYS,
        IWD_BLTU, IWD_BNE, IWD_MULI, IWD_XORHI, IWD_ANDI, IWD_CMPGEI,
        IWD_CMPLTUI, IWD_INITDA, IWD_FLUSHD, IWD_CUSTOM, IWD_RDPRS, IWD_ADD,
        IWD_SUB, IWD_MULXSS, IWD_DIVU, IWD_NOR, IWD_XOR, IWD_SRAI, IWD_ROL,
        IWD_ROR, IWD_SLL, IWD_CMPGEU, IWD_CMPLT, IWD_ERET, IWD_BREAK,
        IWD_NEXTPC, IWD_CALLR, IWD_RDCTL, IWD_INITI, IWD_FLUSHP, IWD_SYNC};

    iwd_fetch_model u_fetch (.clock(CLOCK), .in_valid(IN_VALID),
        .in_word(IN_WORD), .in_pc(IN_PC));

    iwd_decoder u_dut (.CLOCK(CLOCK), .SRST(SRST), .IN_VALID(IN_VALID),
        .IN_WORD(IN_WORD), .IN_PC(IN_PC), .OUT_VALID(OUT_VALID),
        .OUT_FORMAT(OUT_FORMAT), .OUT_OP(OUT_OP),
        .OUT_RESERVED(OUT_RESERVED), .OUT_MAJOR_OPCODE(OUT_MAJOR_OPCODE),
        .OUT_OPCODE_EXTENSION(OUT_OPCODE_EXTENSION), .OUT_SRC_A(OUT_SRC_A),
        .OUT_SRC_B(OUT_SRC_B), .OUT_SRC_B_USED(OUT_SRC_B_USED),
        .OUT_DEST(OUT_DEST), .OUT_SHORT_IMMEDIATE(OUT_SHORT_IMMEDIATE),
        .OUT_IMM_EXT(OUT_IMM_EXT), .OUT_JUMP_IMMEDIATE(OUT_JUMP_IMMEDIATE),
        .OUT_JUMP_TARGET(OUT_JUMP_TARGET));

    ////////////////////////////////////////////////////////////////////////
    // 100 MHz clock
    initial
    begin
        CLOCK = 1'b0;
        forever #5 CLOCK = ~CLOCK;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one word alone; its decode is settled when this returns
    task automatic dec(input logic [31:0] w);
        u_fetch.send(w, 32'hc000_0040);
        u_fetch.idle();
        #1;
    endtask

    task automatic report_and_stop();
        if (failures == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // back to back: immediate word then register word, then an idle cycle
    task automatic t_fields();
        logic [31:0] wi;
        logic [31:0] wr;
        wi = {5'd3, 5'd9, 16'h8001, 6'h04};
        wr = {5'd1, 5'd2, 5'd7, 6'h31, 5'h00, 6'h3a};
        u_fetch.send(wi, 32'ha000_0010);
        u_fetch.send(wr, 32'h5000_0020);
        #1;
        chk(OUT_VALID, 32'd1);
        chk(OUT_SRC_A, 32'd3);
        chk(OUT_DEST, 32'd9);
        chk(OUT_SRC_B_USED, 32'd0);
        chk(OUT_SHORT_IMMEDIATE, 32'h8001);
        chk(OUT_JUMP_TARGET, {4'ha, wi[31:6], 2'b00});
        u_fetch.idle();
        #1;
        chk(OUT_FORMAT, IWD_FMT_R);
        chk(OUT_SRC_B, 32'd2);
        chk(OUT_DEST, 32'd7);
        chk(OUT_OPCODE_EXTENSION, 32'h620);
        chk(OUT_OP, IWD_ADD);
        chk(OUT_JUMP_TARGET, {4'h5, wr[31:6], 2'b00});
        @(posedge CLOCK);
        #1;
        chk(OUT_VALID, 32'd0);
        chk(OUT_DEST, 32'd7);
    endtask

    // negative immediate: logical and unsigned-compare ops zero-extend
    task automatic t_imm_ext();
        logic [5:0] opc [12];
        logic [11:0] zero_ext;
        logic [31:0] exp_imm;
        opc = '{6'h04, 6'h0c, 6'h14, 6'h1c, 6'h2c, 6'h34,
            6'h3c, 6'h30, 6'h28, 6'h08, 6'h24, 6'h17};
        zero_ext = 12'h1fe;
        for (int i = 0; i < 12; i++)
        begin
            dec({10'h000, 16'hfffe, opc[i]});
            exp_imm = zero_ext[i] ? 32'h0000_fffe : 32'hffff_fffe;
            chk(OUT_IMM_EXT, exp_imm);
        end
    endtask

    // every major opcode, and every extension code under 0x3a
    task automatic t_scan();
        logic [5:0] c;
        iwd_fmt_e f;
        for (int i = 0; i < 64; i++)
        begin
            c = 6'(i);
            dec({15'h0000, (c == OPC_RTYPE) ? 6'h31 : 6'h00, 5'h00, c});
            chk(OUT_RESERVED, !OP_DEFINED[i]);
            chk(OUT_OP === IWD_RESERVED, !OP_DEFINED[i]);
            f = (c < 6'h02) ? IWD_FMT_J : IWD_FMT_I;
            if (c == OPC_RTYPE)
                f = IWD_FMT_R;
            if (OP_DEFINED[i])
                chk(OUT_FORMAT, f);
            dec({15'h0000, c, 5'h00, OPC_RTYPE});
            chk(OUT_RESERVED, !EXT_DEFINED[i]);
            chk(OUT_OP === IWD_RESERVED, !EXT_DEFINED[i]);
        end
    endtask

    // a sample of each opcode and extension group maps to its class
    task automatic t_ops();
        logic [5:0] c;
        for (int i = 0; i < 40; i++)
        begin
            c = op_codes[i][5:0];
            if (op_codes[i][6])
                dec({15'h0000, c, 5'h00, OPC_RTYPE});
            else
                dec({26'h000_0000, c});
            if (i < 11)
                chk(OUT_OP, op_exp[i]);
            else if (i < 20)
                chk(OUT_OP, op_exp[i]);
            else if (i < 30)
                chk(OUT_OP, op_exp[i]);
            else
                chk(OUT_OP, op_exp[i]);
        end
    endtask

    // small immediate accepted where used, stray low bits refused elsewhere
    task automatic t_small_imm();
        dec({15'h0000, 6'h12, 5'd5, OPC_RTYPE});
        chk(OUT_OP, IWD_SLLI);
        chk(OUT_IMM_EXT, 32'd5);
        dec({15'h0000, 6'h2d, 5'h1f, OPC_RTYPE});
        chk(OUT_RESERVED, 32'd0);
        chk(OUT_IMM_EXT, 32'h1f);
        dec({15'h0000, 6'h31, 5'd3, OPC_RTYPE});
        chk(OUT_RESERVED, 32'd1);
        dec({15'h0000, 6'h36, 5'h10, OPC_RTYPE});
        chk(OUT_RESERVED, 32'd1);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence: reset for three edges, then each scenario in turn
    initial
    begin
        SRST = 1'b1;
        repeat (3) @(posedge CLOCK);
        SRST <= 1'b0;
        @(posedge CLOCK);
        #1;
        chk(OUT_VALID, 32'd0);
        chk(OUT_OP, IWD_RESERVED);
        t_fields();
        t_imm_ext();
        t_scan();
        t_ops();
        t_small_imm();
        report_and_stop();
    end

    // watchdog: a hung run is cut short and counted as a mismatch
    initial
    begin
        repeat (3000) @(posedge CLOCK);
        failures++;
        report_and_stop();
    end
endmodule
